// ---- verilog/tcw_pkg.sv ----
package tcw_pkg;
  // register byte addresses
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_COUNT = 8'h04;
  localparam logic [7:0] OFS_CMPA = 8'h08;
  localparam logic [7:0] OFS_FLAGS = 8'h0C;
  localparam logic [7:0] OFS_FORCE = 8'h10;
  localparam logic [7:0] OFS_PORT = 8'h14;
  // control fields
  localparam int CTRL_SEL_LSB = 0;
  localparam int CTRL_MODE_LSB = 2;
  localparam int MODE_MSB_POS = 2;
  // flag, force and port fields
  localparam int FLG_OVF = 0;
  localparam int FLG_CMP = 1;
  localparam int FLG_WAVE = 2;
  localparam int FRC_STROBE = 0;
  localparam int PRT_VAL = 0;
  localparam int PRT_DIR = 1;
  localparam int PRT_PIN = 2;
  // waveform modes
  localparam logic [2:0] MODE_NORMAL = 3'h0;
  localparam logic [2:0] MODE_CTC = 3'h2;
  localparam logic [2:0] MODE_FAST_MAX = 3'h3;
  localparam logic [2:0] MODE_FAST_CMP = 3'h7;
  // output actions
  localparam logic [1:0] ACT_NONE = 2'h0;
  localparam logic [1:0] ACT_TOGGLE = 2'h1;
  localparam logic [1:0] ACT_CLEAR = 2'h2;
  localparam logic [1:0] ACT_SET = 2'h3;
  // count values and reset values
  localparam logic [7:0] CNT_MAX = 8'hFF;
  localparam logic [7:0] CNT_BOTTOM = 8'h00;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [2:0] RST_MODE = 3'h0;
  localparam logic [1:0] RST_SEL = 2'h0;
  localparam logic RST_BIT = 1'b0;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
endpackage : tcw_pkg

// ---- verilog/tcw_timer8.sv ----
// The placing of the registers and the AHB-Lite interface to the registers are this design's own decisions.
`timescale 1ns/10ps
// Summary of operation
// - nonzero action select routes internal waveform bit to the pin
// - pin drive enable follows the direction bit; software sets it
// - pin override looks at action select only, never at mode
// - internal waveform bit holds state; actions touch it, not pin
// - action select zero leaves the waveform bit alone on match
// - new action applies at next match; force strobe acts at once in modes 0 and 2
// - count sequence set by mode and compare A, never by action select
// - mode 0 counts up always, wraps 0xFF to 0x00
// - normal mode sets overflow in the tick count becomes zero
// - normal mode accepts count writes at any time
// - mode 2 clears counter on compare A match; A is top
// - clear-on-match uses compare A unbuffered; missed match wraps
// - clear-on-match toggle gives period 2*(1+A) ticks
// - clear-on-match sets overflow when passing max to zero
// - modes 3 and 7 count single slope; top 0xFF or A
// - fast PWM clears the counter on the tick after top
// - fast PWM action 2 clears on match, sets at wrap; 3 inverts
// - fast PWM sets overflow each time counter reaches top
// - mode 3: A zero gives narrow pulse; A max gives constant level
// - fast PWM toggle on match; compare A stays double buffered
// - fast PWM toggle only when mode msb is one
// - equal count sets compare flag next tick; write one clears
module tcw_timer8 (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic CE,
  input wire logic TICK_EN,
  input wire logic HSEL,
  input wire logic [7:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  input wire logic WAVE_PIN_I,
  output logic WAVE_PIN_O,
  output logic WAVE_PIN_OE
);

  function automatic logic is_fast(input logic [2:0] m);
    is_fast = (m == tcw_pkg::MODE_FAST_MAX) ||
              (m == tcw_pkg::MODE_FAST_CMP);
  endfunction : is_fast

  function automatic logic is_nonpwm(input logic [2:0] m);
    is_nonpwm = (m == tcw_pkg::MODE_NORMAL) || (m == tcw_pkg::MODE_CTC);
  endfunction : is_nonpwm

  logic [1:0] sel_q;
  logic [2:0] mode_q;
  logic [7:0] count_q;
  logic [7:0] cmp_buf_q;
  logic [7:0] cmp_act_q;
  logic ovf_q;
  logic cmpf_q;
  logic wave_q;
  logic block_q;
  logic port_val_q;
  logic dir_q;
  logic pin_meta_q;
  logic pin_sync_q;
  logic pin_o_q;
  logic pin_oe_q;
  logic [31:0] hrdata_q;
  logic hready_q;
  logic wr_q;
  logic [7:0] addr_q;

  // bus address phase decode
  wire accept = HSEL & HTRANS[1] & HREADY;
  wire do_wr = wr_q & CE;
  wire wr_ctrl = do_wr & (addr_q == tcw_pkg::OFS_CTRL);
  wire wr_count = do_wr & (addr_q == tcw_pkg::OFS_COUNT);
  wire wr_cmpa = do_wr & (addr_q == tcw_pkg::OFS_CMPA);
  wire wr_flags = do_wr & (addr_q == tcw_pkg::OFS_FLAGS);
  wire wr_force = do_wr & (addr_q == tcw_pkg::OFS_FORCE);
  wire wr_port = do_wr & (addr_q == tcw_pkg::OFS_PORT);

  // timer tick qualified by the clock enable
  wire tk = CE & TICK_EN;
  wire mode_norm = (mode_q == tcw_pkg::MODE_NORMAL);
  wire mode_ctc = (mode_q == tcw_pkg::MODE_CTC);
  wire mode_fast = is_fast(mode_q);
  wire mode_np = is_nonpwm(mode_q);
  wire mode_msb = mode_q[tcw_pkg::MODE_MSB_POS];

  // top value and comparator; compare runs against the active copy
  wire [7:0] top_val = (mode_q == tcw_pkg::MODE_FAST_CMP) ? cmp_act_q :
                       tcw_pkg::CNT_MAX;
  wire at_top = (count_q == top_val);
  wire at_max = (count_q == tcw_pkg::CNT_MAX);
  wire match = (count_q == cmp_act_q) & ~block_q;
  wire fast_wrap = mode_fast & at_top;
  wire force_hit = wr_force & HWDATA[tcw_pkg::FRC_STROBE] & mode_np;

  wire cnt_clr = (mode_ctc & match) | fast_wrap;
  wire cnt_run = mode_norm | mode_ctc | mode_fast;
  wire [7:0] cnt_inc = 8'(count_q + 8'h01);
  wire [7:0] cnt_tick = cnt_clr ? tcw_pkg::CNT_BOTTOM : cnt_inc;
  wire [7:0] count_d = wr_count ? HWDATA[7:0] :
                       (tk & cnt_run) ? cnt_tick : count_q;

  // non-pwm writes go straight to the active compare
  // pwm reload only when the counter wraps
  wire [7:0] cmp_act_d = (wr_cmpa & ~mode_fast) ? HWDATA[7:0] :
                         (tk & fast_wrap) ? cmp_buf_q : cmp_act_q;

  // normal overflow on the wrap tick
  wire ovf_set = tk & (((mode_norm | mode_ctc) & at_max) | fast_wrap);
  wire ovf_clr = wr_flags & HWDATA[tcw_pkg::FLG_OVF];
  wire ovf_d = ovf_set | (ovf_q & ~ovf_clr);

  // compare flag set next tick, write one clears, set wins
  wire cmpf_set = tk & match & cnt_run;
  wire cmpf_clr = wr_flags & HWDATA[tcw_pkg::FLG_CMP];
  wire cmpf_d = cmpf_set | (cmpf_q & ~cmpf_clr);

  // match blocking after a count write lasts until the next tick
  wire block_d = wr_count ? 1'b1 : (tk ? 1'b0 : block_q);

  // current select used at each match
  wire np_act_val = (sel_q == tcw_pkg::ACT_TOGGLE) ? ~wave_q :
                    (sel_q == tcw_pkg::ACT_CLEAR) ? 1'b0 :
                    (sel_q == tcw_pkg::ACT_SET) ? 1'b1 : wave_q;

  // wrap sets for action 2, clears for action 3
  // wrap beats a same-tick match so A at top gives a constant level
  // toggle only with the mode msb set
  wire fast_wrap_val = (sel_q == tcw_pkg::ACT_CLEAR);
  wire fast_match_val = (sel_q == tcw_pkg::ACT_SET);
  wire fast_tog = (sel_q == tcw_pkg::ACT_TOGGLE) & mode_msb;
  wire sel_pwm = sel_q[1];
  wire fast_val = (sel_pwm & fast_wrap) ? fast_wrap_val :
                  (sel_pwm & match) ? fast_match_val :
                  (fast_tog & match) ? ~wave_q : wave_q;

  // actions land on the internal waveform bit
  // toggle per match doubles the count period
  // waveform moves only on ticks, except the force strobe
  wire wave_tick = mode_np ? (match ? np_act_val : wave_q) :
                   mode_fast ? fast_val : wave_q;
  wire wave_d = force_hit ? np_act_val : (tk ? wave_tick : wave_q);

  wire pin_o_d = (sel_q != tcw_pkg::ACT_NONE) ? wave_q : port_val_q;

  // read data mux, unmapped addresses read as zero
  logic [31:0] rdata;
  always_comb begin
    rdata = tcw_pkg::RST_WORD;
    case (HADDR)
      tcw_pkg::OFS_CTRL: begin
        rdata[tcw_pkg::CTRL_SEL_LSB +: 2] = sel_q;
        rdata[tcw_pkg::CTRL_MODE_LSB +: 3] = mode_q;
      end
      tcw_pkg::OFS_COUNT: rdata[7:0] = count_q;
      tcw_pkg::OFS_CMPA: rdata[7:0] = cmp_buf_q;
      tcw_pkg::OFS_FLAGS: begin
        rdata[tcw_pkg::FLG_OVF] = ovf_q;
        rdata[tcw_pkg::FLG_CMP] = cmpf_q;
        rdata[tcw_pkg::FLG_WAVE] = wave_q;
      end
      tcw_pkg::OFS_PORT: begin
        rdata[tcw_pkg::PRT_VAL] = port_val_q;
        rdata[tcw_pkg::PRT_DIR] = dir_q;
        rdata[tcw_pkg::PRT_PIN] = pin_sync_q;
      end
      default: rdata = tcw_pkg::RST_WORD;
    endcase
  end

  // bus slave; read data latched at the address phase, zero wait
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      wr_q <= 1'b0;
      addr_q <= tcw_pkg::RST_BYTE;
      hrdata_q <= tcw_pkg::RST_WORD;
      hready_q <= 1'b1;
    end else if (CE) begin
      wr_q <= accept & HWRITE;
      addr_q <= HADDR;
      hrdata_q <= (accept & ~HWRITE) ? rdata : tcw_pkg::RST_WORD;
      hready_q <= 1'b1;
    end
  end

  // software-written configuration
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      sel_q <= tcw_pkg::RST_SEL;
      mode_q <= tcw_pkg::RST_MODE;
      cmp_buf_q <= tcw_pkg::RST_BYTE;
      port_val_q <= tcw_pkg::RST_BIT;
      dir_q <= tcw_pkg::RST_BIT;
    end else begin
      if (wr_ctrl) begin
        sel_q <= HWDATA[tcw_pkg::CTRL_SEL_LSB +: 2];
        mode_q <= HWDATA[tcw_pkg::CTRL_MODE_LSB +: 3];
      end
      if (wr_cmpa) begin
        cmp_buf_q <= HWDATA[7:0];
      end
      if (wr_port) begin
        port_val_q <= HWDATA[tcw_pkg::PRT_VAL];
        dir_q <= HWDATA[tcw_pkg::PRT_DIR];
      end
    end
  end

  // count writes win over counting at any time
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      count_q <= tcw_pkg::RST_BYTE;
      cmp_act_q <= tcw_pkg::RST_BYTE;
      block_q <= 1'b0;
    end else if (CE) begin
      count_q <= count_d;
      cmp_act_q <= cmp_act_d;
      block_q <= block_d;
    end
  end

  // flags and waveform bit
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      ovf_q <= tcw_pkg::RST_BIT;
      cmpf_q <= tcw_pkg::RST_BIT;
      wave_q <= tcw_pkg::RST_BIT;
    end else if (CE) begin
      ovf_q <= ovf_d;
      cmpf_q <= cmpf_d;
      wave_q <= wave_d;
    end
  end

  // drive enable from direction bit
  // pin input passes two flops before software sees it
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      pin_o_q <= 1'b0;
      pin_oe_q <= 1'b0;
      pin_meta_q <= 1'b0;
      pin_sync_q <= 1'b0;
    end else if (CE) begin
      pin_o_q <= pin_o_d;
      pin_oe_q <= dir_q;
      pin_meta_q <= WAVE_PIN_I;
      pin_sync_q <= pin_meta_q;
    end
  end

  assign HRDATA = hrdata_q;
  assign HREADYOUT = hready_q;
  assign HRESP = 1'b0;
  assign WAVE_PIN_O = pin_o_q;
  assign WAVE_PIN_OE = pin_oe_q;

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RST_N);

  sequence s_norm_step;
    tk & mode_norm & ~wr_count;
  endsequence

  sequence s_fast_top;
    tk & fast_wrap & ~wr_count;
  endsequence

  a_normal_inc: assert property (
    s_norm_step |=> count_q == 8'($past(count_q) + 8'h01))
    else $error("normal mode did not increment");

  a_normal_ovf: assert property (
    s_norm_step ##0 at_max |=> ovf_q && count_q == tcw_pkg::CNT_BOTTOM)
    else $error("normal wrap did not set overflow");

  a_ctc_clear: assert property (
    tk & mode_ctc & match & ~wr_count |=> count_q == tcw_pkg::CNT_BOTTOM)
    else $error("clear-on-match did not clear counter");

  a_fast_wrap: assert property (
    s_fast_top |=> count_q == tcw_pkg::CNT_BOTTOM && ovf_q)
    else $error("fast pwm did not wrap after top");

  a_fast_noninv: assert property (
    s_fast_top ##0 (sel_q == tcw_pkg::ACT_CLEAR) & ~force_hit |=> wave_q)
    else $error("non-inverting output not set at wrap");

  a_cmp_flag: assert property (
    cmpf_set |=> cmpf_q)
    else $error("compare flag lost");

  a_no_action: assert property (
    tk & (sel_q == tcw_pkg::ACT_NONE) & ~force_hit |=> $stable(wave_q))
    else $error("action zero changed waveform bit");

  a_pin_override: assert property (
    CE & (sel_q != tcw_pkg::ACT_NONE) |=> WAVE_PIN_O == $past(wave_q))
    else $error("pin not driven by waveform bit");

  a_pin_dir: assert property (
    CE |=> WAVE_PIN_OE == $past(dir_q))
    else $error("pin enable does not follow direction");

  a_tick_only: assert property (
    ~TICK_EN & ~wr_count & ~force_hit |=> $stable(count_q) && $stable(wave_q))
    else $error("state moved without a tick");

  a_toggle_msb: assert property (
    tk & (mode_q == tcw_pkg::MODE_FAST_MAX) & ~fast_wrap &
    (sel_q == tcw_pkg::ACT_TOGGLE) |=> $stable(wave_q))
    else $error("toggle acted with mode msb clear");

  // a live clear-on-match hit, not hidden behind a count write
  sequence s_ctc_hit;
    tk & mode_ctc & match & ~wr_count;
  endsequence

  a_ctc_toggle: assert property (
    s_ctc_hit ##0 (sel_q == tcw_pkg::ACT_TOGGLE) & ~force_hit |=>
    wave_q != $past(wave_q))
    else $error("clear-on-match toggle missing");

  a_ctc_ovf: assert property (
    tk & mode_ctc & at_max & ~wr_count |=> ovf_q)
    else $error("clear-on-match wrap did not set overflow");

  a_fast_inv: assert property (
    s_fast_top ##0 (sel_q == tcw_pkg::ACT_SET) & ~force_hit |=> !wave_q)
    else $error("inverting output not cleared at wrap");

  a_ovf_hold: assert property (
    ovf_q & ~ovf_clr |=> ovf_q)
    else $error("overflow flag cleared without software");

  a_flag_clear: assert property (
    cmpf_clr & ~cmpf_set |=> !cmpf_q)
    else $error("compare flag not cleared by write one");

  a_count_write: assert property (
    wr_count |=> count_q == $past(HWDATA[7:0]))
    else $error("count write not accepted");

  a_cmp_live: assert property (
    wr_cmpa & ~mode_fast |=> cmp_act_q == $past(HWDATA[7:0]))
    else $error("non-pwm compare write not live");

  a_cmp_buffered: assert property (
    CE & mode_fast & ~(tk & fast_wrap) |=> $stable(cmp_act_q))
    else $error("pwm compare changed away from wrap");

  a_pin_port: assert property (
    CE & (sel_q == tcw_pkg::ACT_NONE) |=> WAVE_PIN_O == $past(port_val_q))
    else $error("pin not driven by port value");

endmodule : tcw_timer8

// ---- bench/tcw_pin_load.sv ----
`timescale 1ns/10ps
// load on the waveform pin; a pull-down holds it low when undriven
module tcw_pin_load (
  input wire logic drv_val,
  input wire logic drv_en,
  output logic pin_level
);
  assign pin_level = drv_en ? drv_val : 1'h0;
endmodule : tcw_pin_load

// ---- bench/tcw_timer8_tb.sv ----
`timescale 1ns/10ps
module tcw_timer8_tb;
  typedef struct {
    string name;
    logic [31:0] exp;
  } tcw_note_s;
  localparam logic [7:0] A_CTL = tcw_pkg::OFS_CTRL;
  localparam logic [7:0] A_CNT = tcw_pkg::OFS_COUNT;
  localparam logic [7:0] A_CMP = tcw_pkg::OFS_CMPA;
  localparam logic [7:0] A_FLG = tcw_pkg::OFS_FLAGS;
  localparam logic [7:0] A_FRC = tcw_pkg::OFS_FORCE;
  localparam logic [7:0] A_PRT = tcw_pkg::OFS_PORT;
  logic CLK, RST_N, CE, TICK_EN, HSEL, HWRITE, HREADYOUT;
  logic [7:0] HADDR, a, c, k;
  logic [1:0] HTRANS;
  logic [2:0] HSIZE, m;
  logic [31:0] HWDATA, HRDATA, meas_val;
  logic WAVE_PIN_O, WAVE_PIN_OE, pin, rd_phase, meas_v, b;
  logic [1:0] sel_seq [4] = '{2'h0, 2'h1, 2'h3, 2'h2};
  logic [1:0] pwm_sel [6] = '{2'h2, 2'h3, 2'h2, 2'h3, 2'h1, 2'h1};
  tcw_note_s notes[$];
  tcw_note_s nt;
  int num_errors, n_tests, w, h;

  tcw_timer8 tcw_timer8_i (.CLK(CLK), .RST_N(RST_N), .CE(CE),
    .TICK_EN(TICK_EN), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
    .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADYOUT),
    .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(), .WAVE_PIN_I(pin),
    .WAVE_PIN_O(WAVE_PIN_O), .WAVE_PIN_OE(WAVE_PIN_OE));
  tcw_pin_load tcw_pin_load_i (.drv_val(WAVE_PIN_O), .drv_en(WAVE_PIN_OE),
    .pin_level(pin));

  initial begin
    CLK = 1'h0;
    forever #12.5 CLK = ~CLK;
  end

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : end_of_test

  // bounded wait for ready; a hung slave ends the run
  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      @(posedge CLK);
      n++;
    end while (HREADYOUT !== 1'h1 && n < 20);
    if (HREADYOUT !== 1'h1) begin
      num_errors++;
      end_of_test();
    end
  endtask : wait_rdy

  // one single word transfer, entered just after a rising edge
  task automatic bus(input logic wr, input logic [7:0] ad,
                     input logic [31:0] d);
    HSEL <= 1'h1;
    HTRANS <= 2'h2;
    HADDR <= ad;
    HWRITE <= wr;
    HSIZE <= 3'h2;
    wait_rdy();
    HSEL <= 1'h0;
    HTRANS <= 2'h0;
    HWDATA <= d;
    rd_phase <= ~wr;
    wait_rdy();
    rd_phase <= 1'h0;
  endtask : bus

  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    bus(1'h1, ad, d);
  endtask : wr

  task automatic rd(input logic [7:0] ad, input logic [31:0] e,
                    input string nm);
    notes.push_back('{nm, e});
    bus(1'h0, ad, 32'h0);
  endtask : rd

  task automatic tick(input int n);
    TICK_EN <= 1'h1;
    repeat (n) @(posedge CLK);
    TICK_EN <= 1'h0;
  endtask : tick

  function automatic logic [31:0] ctl(input logic [2:0] md,
                                      input logic [1:0] sl);
    return (32'(md) << tcw_pkg::CTRL_MODE_LSB) |
      (32'(sl) << tcw_pkg::CTRL_SEL_LSB);
  endfunction : ctl

  // results are matched in order against the oldest note
  always @(posedge CLK) begin
    if ((rd_phase === 1'h1 && HREADYOUT === 1'h1) || meas_v === 1'h1) begin
      n_tests++;
      nt = notes.pop_front();
      if ((meas_v === 1'h1 ? meas_val : HRDATA) !== nt.exp) begin
        $display("wrong value %s expected %h seen %h", nt.name, nt.exp,
          meas_v === 1'h1 ? meas_val : HRDATA);
        num_errors++;
      end
    end
  end

  initial begin
    {CE, RST_N, TICK_EN, HSEL, HWRITE, rd_phase, meas_v} = 7'h40;
    {HADDR, HTRANS, HSIZE, HWDATA, meas_val} = '0;
    void'($urandom(32'hA1EEBC07));
    repeat (2) @(posedge CLK);
    RST_N <= 1'h1;
    @(posedge CLK);
    // reset values, including the unmapped word after the port
    for (int i = 0; i < 7; i++) rd(8'(i * 4), 32'h0, "reset word");
    $display("test reset done");
    b = 1'($urandom);
    wr(A_PRT, {31'h0, b});
    repeat (4) @(posedge CLK);
    rd(A_PRT, {31'h0, b}, "port undriven");
    wr(A_PRT, {30'h0, 1'h1, b});
    repeat (4) @(posedge CLK);
    rd(A_PRT, {29'h0, b, 1'h1, b}, "port driven");
    wr(A_PRT, 32'h2);
    wr(A_CTL, ctl(tcw_pkg::MODE_NORMAL, tcw_pkg::ACT_SET));
    wr(A_FRC, 32'h1);
    rd(A_FLG, 32'h4, "forced flags");
    // the pin input needs two more edges through its synchroniser
    repeat (2) @(posedge CLK);
    rd(A_PRT, 32'h6, "override pin");
    wr(A_CTL, ctl(tcw_pkg::MODE_FAST_MAX, tcw_pkg::ACT_SET));
    rd(A_PRT, 32'h6, "pwm override");
    for (int i = 0; i < 4; i++) begin
      wr(A_CTL, ctl(tcw_pkg::MODE_NORMAL, sel_seq[i]));
      wr(A_FRC, 32'h1);
      rd(A_FLG, i % 2 == 0 ? 32'h4 : 32'h0, "force action");
    end
    repeat (2) @(posedge CLK);
    rd(A_PRT, 32'h2, "port restored");
    $display("test override done");
    // normal mode wraps past the top into a small count
    c = 8'h80 | 8'($urandom);
    k = 8'($urandom % 16);
    wr(A_CMP, {24'h0, k + 8'h01});
    wr(A_CNT, {24'h0, c});
    tick(256 - c + k);
    repeat (3) @(posedge CLK);
    rd(A_CNT, {24'h0, k}, "normal count");
    rd(A_FLG, 32'h1, "overflow");
    wr(A_FLG, 32'h1);
    rd(A_FLG, 32'h0, "flag clear");
    $display("test normal done");
    // clear-on-match toggles with period 2*(1+A)
    a = 8'(6 + $urandom % 26);
    wr(A_CMP, {24'h0, a});
    wr(A_CNT, 32'h0);
    wr(A_CTL, ctl(tcw_pkg::MODE_CTC, tcw_pkg::ACT_TOGGLE));
    tick(a + 1);
    rd(A_CNT, 32'h0, "ctc count");
    rd(A_FLG, 32'h6, "ctc first");
    tick(a + 1);
    rd(A_FLG, 32'h2, "ctc second");
    wr(A_FLG, 32'h3);
    tick(5);
    wr(A_CMP, 32'h2);
    tick(251);
    rd(A_FLG, 32'h1, "missed match");
    tick(3);
    rd(A_FLG, 32'h7, "late match");
    $display("test ctc done");
    // fast pwm: count high cycles of the pin over one period
    for (int i = 0; i < 6; i++) begin
      m = i == 4 ? tcw_pkg::MODE_FAST_CMP : tcw_pkg::MODE_FAST_MAX;
      a = i == 2 ? 8'h00 : i == 3 ? 8'hFF : 8'(1 + $urandom % 60);
      w = m == tcw_pkg::MODE_FAST_CMP ? 2 * (a + 1) : 256;
      wr(A_CTL, ctl(tcw_pkg::MODE_NORMAL, tcw_pkg::ACT_CLEAR));
      wr(A_FRC, 32'h1);
      wr(A_CMP, {24'h0, a});
      wr(A_CNT, 32'h0);
      wr(A_FLG, 32'h3);
      wr(A_CTL, ctl(m, pwm_sel[i]));
      h = 0;
      TICK_EN <= 1'h1;
      for (int j = 0; j < 2 * w; j++) begin
        // sample mid-cycle where the pin has settled
        @(negedge CLK);
        if (j >= w && pin === 1'h1) h++;
        @(posedge CLK);
      end
      TICK_EN <= 1'h0;
      notes.push_back('{"pin highs", pwm_sel[i] == 2'h2 ? a + 1 :
        pwm_sel[i] == 2'h3 ? 255 - a : i == 4 ? a + 1 : 0});
      meas_val <= h;
      meas_v <= 1'h1;
      @(posedge CLK);
      meas_v <= 1'h0;
      rd(A_CNT, 32'h0, "pwm count");
      rd(A_FLG, (pwm_sel[i] == 2'h2) ? 32'h7 : 32'h3, "pwm flags");
    end
    $display("test pwm done");
    repeat (4) @(posedge CLK);
    end_of_test();
  end
endmodule : tcw_timer8_tb
